// ---- core/std_event_status_regs.sv ----
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module std_event_status_regs
  import event_status_pkg::*;
(
  // clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_n,
  // enable-set command
  input  wire logic         i_mask_wr,
  input  wire mask_arg_type i_mask_arg,
  // queries
  input  wire logic         i_mask_rd,
  input  wire logic         i_status_rd,
  // event sources, one pulse per event
  input  wire logic [7:0]   i_event_set,
  // answers
  output reply_type         o_mask_reply,
  output reply_type         o_status_reply,
  // status state
  output logic [7:0]        o_mask,
  output logic [7:0]        o_status,
  output logic              o_event_summary
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release; the assert stays asynchronous, only the release is timed
  logic       rst_meta_q;
  logic       rst_sync_q;
  logic       rst_n;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // mask and status registers
  logic [7:0] rounded_arg;
  logic [7:0] mask_q;
  logic [7:0] mask_d;
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [7:0] events_in;
  reply_type  mask_reply_q;
  reply_type  status_reply_q;
  logic       summary_q;

  mask_arg_round mask_arg_round_i (
    .i_arg   (i_mask_arg),
    .o_value (rounded_arg)
  );

  // binary weight: value passes straight onto bits 7..0
  assign mask_d    = i_mask_wr ? rounded_arg : mask_q;
  // unused bits never latch
  assign events_in = i_event_set & ~UNUSED_BITS;
  // new event in the read cycle wins over the clear, so no event is lost
  // only the query clears here; the separate clear command lives elsewhere
  // one cell per bit; unused bits are masked ahead, so every cell is alike
  for (genvar b = 0; b < REG_WIDTH; b++) begin : g_status_bit
    assign status_d[b] = (i_status_rd ? STATUS_CLEAR[b] : status_q[b]) | events_in[b];
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= MASK_RESET;
      status_q <= STATUS_RESET;
    end else begin
      mask_q <= mask_d;
      status_q <= status_d;
    end
  end

  // reply value follows the register every cycle; only valid marks an answer
  // summary taken from next-state values so it lines up with the registers
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reply_q <= '0;
      status_reply_q <= '0;
      summary_q <= 1'b0;
    end else begin
      mask_reply_q <= '{valid: i_mask_rd, value: mask_q};
      status_reply_q <= '{valid: i_status_rd, value: status_q};
      summary_q <= |(status_d & mask_d);
    end
  end

  assign o_mask_reply    = mask_reply_q;
  assign o_status_reply  = status_reply_q;
  assign o_mask          = mask_q;
  assign o_status        = status_q;
  assign o_event_summary = summary_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // mask register
  a_mask_load_value: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    i_mask_wr |=> o_mask == $past(rounded_arg))
    else $error("mask not loaded from argument");

  a_mask_saturate: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (i_mask_wr && i_mask_arg.int_part > ARG_MAX)
    |=> o_mask == ARG_MAX[7:0])
    else $error("oversized argument not saturated");

  a_round_half_up: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (i_mask_wr && i_mask_arg.int_part < ARG_MAX && i_mask_arg.frac_digit >= ROUND_UP_FROM)
    |=> o_mask == $past(i_mask_arg.int_part[7:0]) + 8'h01)
    else $error("fraction not rounded up");

  a_round_top_end: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (i_mask_wr && i_mask_arg.int_part == ARG_MAX && i_mask_arg.frac_digit >= ROUND_UP_FROM)
    |=> o_mask == ARG_MAX[7:0])
    else $error("top value rounded past the mask");

  a_round_down: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (i_mask_wr && i_mask_arg.int_part <= ARG_MAX && i_mask_arg.frac_digit < ROUND_UP_FROM)
    |=> o_mask == $past(i_mask_arg.int_part[7:0]))
    else $error("fraction not dropped");

  a_mask_reset_zero: assert property (@(posedge i_core_clk)
    $rose(rst_n) |-> o_mask == MASK_RESET)
    else $error("mask not zero after reset");

  a_reset_all_idle: assert property (@(posedge i_core_clk)
    $rose(rst_n) |-> o_status == STATUS_RESET && !o_event_summary
    && !o_mask_reply.valid && !o_status_reply.valid)
    else $error("outputs not idle after reset");

  a_mask_query_value: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (i_mask_rd && !i_mask_wr) |=> o_mask_reply.valid && o_mask_reply.value == o_mask
    && o_mask == $past(o_mask))
    else $error("mask query wrong or altered mask");

  a_mask_query_old: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (i_mask_rd && i_mask_wr)
    |=> o_mask_reply.value == $past(o_mask))
    else $error("query beside a write not answered with old mask");

  a_mask_reply_pulse: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    ##1 o_mask_reply.valid == $past(i_mask_rd))
    else $error("mask reply not a single pulse");

  a_mask_hold_idle: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    !i_mask_wr
    |=> o_mask == $past(o_mask))
    else $error("mask changed without a write");

  ////////////////////////////////////////////////////////////////////////////
  // status register

  a_status_query_clear: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (i_status_rd && i_event_set == 8'h00) |=> o_status_reply.valid
    && o_status_reply.value == $past(o_status) && o_status == STATUS_CLEAR)
    else $error("status query not returned then cleared");

  a_status_reply_old: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    i_status_rd
    |=> o_status_reply.value == $past(o_status))
    else $error("status reply not the value before the clear");

  a_status_reply_pulse: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    ##1 o_status_reply.valid == $past(i_status_rd))
    else $error("status reply not a single pulse");

  a_event_not_lost: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    i_status_rd ##0 (i_event_set[BIT_OPC]) |=> o_status[BIT_OPC])
    else $error("event lost on clear");

  a_event_latched: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    ##1 (o_status & $past(events_in)) == $past(events_in))
    else $error("event not latched");

  a_status_keeps_bits: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    !i_status_rd
    |=> (o_status & $past(o_status)) == $past(o_status))
    else $error("status bit lost without a query");

  a_status_no_stray: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    ##1 (o_status & ~$past(o_status) & ~$past(events_in)) == 8'h00)
    else $error("status bit set without an event");

  a_unused_bits_zero: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (o_status & UNUSED_BITS) == 8'h00)
    else $error("unused status bit set");

  ////////////////////////////////////////////////////////////////////////////
  // event summary

  a_summary_and: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    ##1 o_event_summary == |(o_status & o_mask))
    else $error("summary bit mismatch");

  a_summary_rises: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (|(events_in & o_mask) && !i_mask_wr)
    |=> o_event_summary)
    else $error("enabled event did not raise summary");

  a_summary_clears: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (i_status_rd && i_event_set == 8'h00)
    |=> !o_event_summary)
    else $error("summary stayed after status query");

  a_summary_no_mask: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (o_mask == 8'h00) |-> !o_event_summary)
    else $error("summary set with empty mask");

endmodule // std_event_status_regs

// ---- common/event_status_pkg.sv ----
package event_status_pkg;

  localparam int unsigned REG_WIDTH = 8;

  // reset and clear values
  localparam logic [7:0] MASK_RESET   = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] STATUS_CLEAR = 8'h00;

  // event bit positions within the status register
  localparam int unsigned BIT_OPC = 0;
  localparam int unsigned BIT_RQC = 1;
  localparam int unsigned BIT_QYE = 2;
  localparam int unsigned BIT_DDE = 3;
  localparam int unsigned BIT_EXE = 4;
  localparam int unsigned BIT_CME = 5;
  localparam int unsigned BIT_URQ = 6;
  localparam int unsigned BIT_PON = 7;

  // bits never set by this unit
  localparam logic [7:0] UNUSED_BITS = 8'h42;

  // decoded argument of the enable-set command:
  // integer part plus the first fractional digit
  typedef struct packed {
    logic [9:0] int_part;
    logic [3:0] frac_digit;
  } mask_arg_type;

  // one query answer
  typedef struct packed {
    logic       valid;
    logic [7:0] value;
  } reply_type;

  // argument limits
  localparam logic [9:0] ARG_MAX       = 10'h0FF;
  localparam logic [3:0] ROUND_UP_FROM = 4'h5;

endpackage

// ---- core/mask_arg_round.sv ----
`timescale 1ns/10ps
// rounds a decimal argument to the nearest integer and clamps it to 0..255
module mask_arg_round
  import event_status_pkg::*;
(
  // argument in
  input  wire mask_arg_type i_arg,
  // rounded result
  output logic [7:0]        o_value
);

  logic [10:0] rounded;
  logic        round_up;

  assign round_up = (i_arg.frac_digit >= ROUND_UP_FROM);
  assign rounded  = {1'b0, i_arg.int_part} + {10'h000, round_up};
  // out of range arguments saturate rather than wrap
  assign o_value  = (rounded > {1'b0, ARG_MAX}) ? ARG_MAX[7:0] : rounded[7:0];

endmodule // mask_arg_round

// ---- tb/remote_host.sv ----
`timescale 1ns/10ps
module remote_host
  import event_status_pkg::*;
(
  // clock
  input  wire logic   i_core_clk,
  // commands and events
  output mask_arg_type o_arg,
  output logic         o_wr,
  output logic         o_rd,
  output logic         o_srd,
  output logic [7:0]   o_ev
);
  initial begin
    o_arg = '0;
    o_wr  = 1'b0;
    o_rd  = 1'b0;
    o_srd = 1'b0;
    o_ev  = 8'h00;
  end
  // one strobe cycle, then all strobes drop; value bit n weighs 2 to n
  task automatic issue(input logic w, input logic [9:0] ip, input logic [3:0] fd,
                       input logic r, input logic s, input logic [7:0] e);
    @(posedge i_core_clk);
    o_wr  <= w;
    o_arg <= '{int_part: ip, frac_digit: fd};
    o_rd  <= r;
    o_srd <= s;
    o_ev  <= e;
    @(posedge i_core_clk);
    o_wr  <= 1'b0;
    o_rd  <= 1'b0;
    o_srd <= 1'b0;
    o_ev  <= 8'h00;
    // let the taking edge land before anyone looks
    #1;
  endtask
endmodule // remote_host

// ---- tb/std_event_status_regs_bench.sv ----
`timescale 1ns/10ps
module std_event_status_regs_bench;
  import event_status_pkg::*;
  logic         i_core_clk;
  logic         i_rst_n;
  mask_arg_type arg;
  logic         wr, rd, srd;
  logic [7:0]   ev, o_mask, o_status;
  reply_type    o_mask_reply, o_status_reply;
  logic         o_event_summary;
  int           miscompares = 0;
  int           checks = 0;
  logic [9:0]   ip [4] = '{10'h00C, 10'h00C, 10'h12C, 10'h0FF};
  logic [3:0]   fd [4] = '{4'h5, 4'h4, 4'h0, 4'h9};
  logic [8:0]   ex [4] = '{9'h00D, 9'h00C, 9'h0FF, 9'h0FF};
  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  remote_host remote_host_i (.i_core_clk(i_core_clk), .o_arg(arg), .o_wr(wr), .o_rd(rd),
                             .o_srd(srd), .o_ev(ev));
  std_event_status_regs std_event_status_regs_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_mask_wr(wr), .i_mask_arg(arg), .i_mask_rd(rd), .i_status_rd(srd), .i_event_set(ev),
    .o_mask_reply(o_mask_reply), .o_status_reply(o_status_reply), .o_mask(o_mask),
    .o_status(o_status), .o_event_summary(o_event_summary));
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    i_rst_n = 1'b0;
    repeat (10) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    #1;
    chk("mask", 9'h000, {1'b0, o_mask});
    // 255.9 rounds past the top, so it must saturate
    for (int k = 0; k < 4; k++) begin
      remote_host_i.issue(1'b1, ip[k], fd[k], 1'b0, 1'b0, 8'h00);
      chk("mask", ex[k], {1'b0, o_mask});
    end
    remote_host_i.issue(1'b1, 10'h024, 4'h0, 1'b0, 1'b0, 8'h00);
    chk("mask", 9'h024, {1'b0, o_mask});
    remote_host_i.issue(1'b0, 10'h000, 4'h0, 1'b1, 1'b0, 8'h00);
    chk("mask_reply", 9'h124, o_mask_reply);
    chk("mask", 9'h024, {1'b0, o_mask});
    remote_host_i.issue(1'b0, 10'h000, 4'h0, 1'b0, 1'b0, 8'hFF);
    chk("status", 9'h0BD, {1'b0, o_status});
    chk("summary", 9'h001, {8'h00, o_event_summary});
    remote_host_i.issue(1'b0, 10'h000, 4'h0, 1'b0, 1'b1, 8'h00);
    chk("status_reply", 9'h1BD, o_status_reply);
    chk("status", 9'h000, {1'b0, o_status});
    chk("summary", 9'h000, {8'h00, o_event_summary});
    // query beside a write answers the old mask
    remote_host_i.issue(1'b1, 10'h081, 4'h0, 1'b1, 1'b0, 8'h01);
    chk("mask_reply", 9'h124, o_mask_reply);
    chk("mask", 9'h081, {1'b0, o_mask});
    chk("summary", 9'h001, {8'h00, o_event_summary});
    // an event in the query cycle survives the clear
    remote_host_i.issue(1'b0, 10'h000, 4'h0, 1'b0, 1'b1, 8'h01);
    chk("status_reply", 9'h101, o_status_reply);
    chk("status", 9'h001, {1'b0, o_status});
    chk("mask_reply", 9'h081, o_mask_reply);
    remote_host_i.issue(1'b0, 10'h000, 4'h0, 1'b0, 1'b1, 8'h00);
    chk("status", 9'h000, {1'b0, o_status});
    chk("summary", 9'h000, {8'h00, o_event_summary});
    // mid-run reset must clear a loaded mask
    remote_host_i.issue(1'b0, 10'h000, 4'h0, 1'b0, 1'b0, 8'h01);
    @(posedge i_core_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    #1;
    chk("mask", 9'h000, {1'b0, o_mask});
    chk("summary", 9'h000, {8'h00, o_event_summary});
    end_sim();
  end
endmodule // std_event_status_regs_bench
